// ### src/uacp_pkg.sv
// Purpose: Shared constants and types of the serial command port
// Assumes: 25 MHz core clock
// Notes: Timeout counts are derived from the modulator period
package uacp_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam longint CLK_PERIOD_PS = 40000;
   // Line coding
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam logic [2:0] SYNC_LAST_FALL = 3'h3;
   localparam int BAUD_W = 16;
   localparam int MEAS_W = 19;
   localparam logic [BAUD_W-1:0] BAUD_DEFAULT = 16'h00D9;
   // Command bytes, lowest bit ignored
   localparam logic [7:0] RESET_CMD = 8'h06;
   localparam logic [7:0] START_CMD = 8'h08;
   localparam logic [7:0] SLEEP_CMD = 8'h02;
   localparam logic [3:0] READ_DATA_NIB = 4'h1;
   localparam logic [3:0] REG_READ_NIB = 4'h2;
   localparam logic [3:0] REG_WRITE_NIB = 4'h4;
   // Configuration registers
   localparam int NUM_REGS = 5;
   localparam logic [2:0] LAST_REG = 3'h4;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int MODE_REG = 1;
   localparam int CONV_MODE_BIT = 3;
   localparam int TURBO_BIT = 4;
   localparam logic [2:0] FIFTH_CONFIG_REG = 3'h4;
   localparam int PIN_DIR_BIT = 6;
   localparam int PIN_SEL_BIT = 3;
   localparam int PIN_DAT_BIT = 2;
   // Result format
   localparam int RESULT_W = 24;
   localparam int RAW_W = 26;
   localparam logic [RESULT_W-1:0] RESULT_MAX = 24'h7F_FFFF;
   localparam logic [RESULT_W-1:0] RESULT_MIN = 24'h80_0000;
   localparam logic signed [RAW_W-1:0] RAW_POS_LIMIT = 26'sh07F_FFFF;
   localparam logic signed [RAW_W-1:0] RAW_NEG_LIMIT = 26'sh380_0000;
   // Interface timeout
   localparam longint MODULATOR_PERIOD_NORMAL_PS = 3906250;
   localparam longint MODULATOR_PERIOD_TURBO_PS = 1953125;
   localparam longint TIMEOUT_NORMAL_MODS = 32760;
   localparam longint TIMEOUT_TURBO_MODS = 65520;
   localparam int TIMEOUT_NORMAL_CYC =
      int'((TIMEOUT_NORMAL_MODS * MODULATOR_PERIOD_NORMAL_PS) / CLK_PERIOD_PS);
   localparam int TIMEOUT_TURBO_CYC =
      int'((TIMEOUT_TURBO_MODS * MODULATOR_PERIOD_TURBO_PS) / CLK_PERIOD_PS);
   localparam int TIMER_W = 22;
   // Ready high pulse when a result is overwritten unread
   localparam int READY_HIGH_PULSE_WIDTH_NS = 200;
   localparam logic [3:0] READY_PULSE_CYC =
      4'((READY_HIGH_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } uacp_txreq_t;
endpackage

// ### src/uacp_tx.sv
// Purpose: 8-N-1 byte transmitter timed by the measured bit period
// Assumes: bitPeriod is at least one cycle and stable during a byte
// Notes: Line idles high
`timescale 1ns/10ps
`default_nettype none
module uacp_tx (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [uacp_pkg::BAUD_W-1:0] bitPeriod,
   input wire uacp_pkg::uacp_txreq_t txReq,
   output logic txReady,
   output logic txLine,
   output logic txBusy
);
   import uacp_pkg::*;

   logic [9:0] shift;
   logic [3:0] bitIdx;
   logic [BAUD_W-1:0] cycCnt;

   assign txReady = ~txBusy;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txBusy <= 1'b0;
         txLine <= 1'b1;
         shift <= 10'h3FF;
         bitIdx <= 4'h0;
         cycCnt <= '0;
      end else if (!txBusy) begin
         txLine <= 1'b1;
         if (txReq.valid) begin
            shift <= {1'b1, txReq.data, 1'b0};
            txLine <= 1'b0;
            txBusy <= 1'b1;
            bitIdx <= 4'h0;
            cycCnt <= bitPeriod - 1'b1;
         end
      end else if (cycCnt != '0) begin
         cycCnt <= cycCnt - 1'b1;
      end else if (bitIdx == 4'h9) begin
         txBusy <= 1'b0;
         txLine <= 1'b1;
      end else begin
         shift <= {1'b1, shift[9:1]};
         txLine <= shift[1];
         bitIdx <= bitIdx + 1'b1;
         cycCnt <= bitPeriod - 1'b1;
      end
   end

   a_tx_idle_high: assert property (@(posedge core_clk) disable iff (sys_rst)
      !txBusy |-> txLine)
      else $error("transmit line low while idle");

   a_tx_start_low: assert property (@(posedge core_clk) disable iff (sys_rst)
      (txReq.valid && txReady) |=> (!txLine && txBusy)[*1] ##1 !txLine)
      else $error("start bit not driven low");
endmodule
`default_nettype wire

// ### src/uacp_core.sv
// Purpose: Serial command port of a delta-sigma converter
// Assumes: Conversion engine runs on core_clk; rxPin and sharedGpIn are async
// Notes: Bit period is relearned from the sync byte for every command
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Sleep command lets a running conversion finish; asleep keeps config, starts nothing.
// - Start command wakes from sleep and starts single or continuous conversion.
// - Half duplex; never transmit while receiving, never receive while transmitting.
// - Receive pin is input only; transmit line idles high.
// - Ready appears on the shared pin only when output and function-select set.
// - Ready falls on a new result, rises when it is loaded for sending.
// - Continuous unread result: ready pulses high briefly for the newer result.
// - Bytes framed low start, eight data bits LSB first, high stop.
// - Every command is preceded by a sync byte that relearns the baud rate.
// - Idle timeout mid command resets the serial interface.
// - Results are 24-bit twos complement, clipped at full scale.
// - Reset, start and sleep command bytes decoded, lowest bit ignored.
// - Register commands carry address in bits three to one, valid zero to four.
// - Reset command restores defaults; host then waits before next command.
// - Single mode start begins one conversion, restarting one already running.
// - Continuous mode start runs repeatedly; another start restarts the sequence.
// - Waking restores analog and current sources to their state before sleep.
// - Read data loads newest result at once; a same-time completion keeps ready low; in continuous mode with a result unread, ready first pulses high.
// - Words go least significant byte first, each byte LSB first.
// - Register read of a missing address returns zero.
// - Register write stores valid address, else ignored; accepted write restarts conversion.
// - A received byte is taken only on detecting its stop bit mid-bit.
module uacp_core #(
   parameter int TIMEOUT_NORMAL_CYCLES = uacp_pkg::TIMEOUT_NORMAL_CYC,
   parameter int TIMEOUT_TURBO_CYCLES = uacp_pkg::TIMEOUT_TURBO_CYC
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic rxPin,
   output logic txPin,
   input wire logic sharedGpPinIn,
   output logic sharedGpPinOut,
   output logic sharedGpPinOe,
   output logic conversionReadyN,
   output logic convStart,
   output logic convRun,
   input wire logic convDone,
   input wire logic signed [uacp_pkg::RAW_W-1:0] convRaw,
   output logic analogPowerOn,
   output logic excitationCurrentSourceOn,
   output logic turboMode
);
   import uacp_pkg::*;

   typedef enum logic [2:0] {
      ST_SYNC_WAIT, ST_SYNC_MEAS, ST_SYNC_END, ST_CMD, ST_WDATA, ST_TX
   } uacp_cmd_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uacp_rx_state_t;

   function automatic logic matchCmd(input logic [7:0] b, input logic [7:0] code);
      return b[7:1] == code[7:1];
   endfunction

   function automatic logic [RESULT_W-1:0] clipRaw(input logic signed [RAW_W-1:0] raw);
      if (raw > RAW_POS_LIMIT) begin
         return RESULT_MAX;
      end else if (raw < RAW_NEG_LIMIT) begin
         return RESULT_MIN;
      end
      return raw[RESULT_W-1:0];
   endfunction

   uacp_cmd_state_t cmdState;
   uacp_rx_state_t rxState;
   logic rxMeta, rxSync, rxPrev, gpMeta, gpSync;
   logic rxFall, rxEdge, rxEnable;
   logic [BAUD_W-1:0] bitPeriod, rxCnt;
   logic [MEAS_W-1:0] measCnt;
   logic [2:0] fallCnt, rxBitIdx, wrAddr;
   logic [7:0] rxShift, rxByte, readVal;
   logic rxByteValid;
   logic [7:0] cfgReg [NUM_REGS];
   logic cmdLatch, doReset, doStart, doSleep, doRdata, doRreg, doWreg;
   logic doWrite, writeOk;
   logic asleep, converting, pendingSleep, newRes, unread;
   logic [RESULT_W-1:0] resultLatest, txBuf;
   logic [1:0] txLeft;
   logic [3:0] pulseCnt;
   logic [TIMER_W-1:0] idleCnt, idleLimit;
   logic timerActive, timedOut;
   logic convMode, pinDir, pinSel;
   uacp_txreq_t txReq;
   logic txReady, txBusy, txAccept;

   // Pin synchronisers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
         rxPrev <= 1'b1;
         gpMeta <= 1'b0;
         gpSync <= 1'b0;
      end else begin
         rxMeta <= rxPin;
         rxSync <= rxMeta;
         rxPrev <= rxSync;
         gpMeta <= sharedGpPinIn;
         gpSync <= gpMeta;
      end
   end

   assign rxFall = rxPrev & ~rxSync;
   assign rxEdge = rxPrev ^ rxSync;
   assign rxEnable = (cmdState == ST_CMD) || (cmdState == ST_WDATA);

   assign convMode = cfgReg[MODE_REG][CONV_MODE_BIT];
   assign turboMode = cfgReg[MODE_REG][TURBO_BIT];
   assign pinDir = cfgReg[FIFTH_CONFIG_REG][PIN_DIR_BIT];
   assign pinSel = cfgReg[FIFTH_CONFIG_REG][PIN_SEL_BIT];

   // Baud measurement over four bit pairs of the sync byte
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         measCnt <= '0;
         fallCnt <= 3'h0;
         bitPeriod <= BAUD_DEFAULT;
      end else if (cmdState == ST_SYNC_WAIT) begin
         // Count the cycle of the first fall too, so eight bits give 8*T
         measCnt <= {{(MEAS_W-1){1'b0}}, 1'b1};
         fallCnt <= 3'h0;
      end else if (cmdState == ST_SYNC_MEAS) begin
         if (measCnt != '1) begin
            measCnt <= measCnt + 1'b1;
         end
         if (rxFall) begin
            fallCnt <= fallCnt + 1'b1;
            if (fallCnt == SYNC_LAST_FALL) begin
               if (measCnt[MEAS_W-1:3] == '0) begin
                  bitPeriod <= 16'h0001;
               end else begin
                  bitPeriod <= measCnt[MEAS_W-1:3];
               end
            end
         end
      end
   end

   // Byte receiver
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxState <= RX_IDLE;
         rxCnt <= '0;
         rxBitIdx <= 3'h0;
         rxShift <= 8'h00;
         rxByte <= 8'h00;
         rxByteValid <= 1'b0;
      end else begin
         rxByteValid <= 1'b0;
         if (!rxEnable || timedOut) begin
            rxState <= RX_IDLE;
         end else if (rxState != RX_IDLE && rxCnt != '0) begin
            rxCnt <= rxCnt - 1'b1;
         end else begin
            unique case (rxState)
               RX_IDLE: begin
                  if (rxFall) begin
                     rxState <= RX_START;
                     rxCnt <= {1'b0, bitPeriod[BAUD_W-1:1]};
                  end
               end
               RX_START: begin
                  rxCnt <= bitPeriod - 1'b1;
                  rxBitIdx <= 3'h0;
                  rxState <= rxSync ? RX_IDLE : RX_DATA;
               end
               RX_DATA: begin
                  rxShift <= {rxSync, rxShift[7:1]};
                  rxCnt <= bitPeriod - 1'b1;
                  rxBitIdx <= rxBitIdx + 1'b1;
                  if (rxBitIdx == 3'h7) begin
                     rxState <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rxSync) begin
                     rxByteValid <= 1'b1;
                     rxByte <= rxShift;
                  end
                  rxState <= RX_IDLE;
               end
            endcase
         end
      end
   end

   // Command decode
   assign cmdLatch = rxByteValid && (cmdState == ST_CMD);
   assign doReset = cmdLatch && matchCmd(rxByte, RESET_CMD);
   assign doStart = cmdLatch && matchCmd(rxByte, START_CMD);
   assign doSleep = cmdLatch && matchCmd(rxByte, SLEEP_CMD);
   assign doRdata = cmdLatch && (rxByte[7:4] == READ_DATA_NIB);
   assign doRreg = cmdLatch && (rxByte[7:4] == REG_READ_NIB);
   assign doWreg = cmdLatch && (rxByte[7:4] == REG_WRITE_NIB);
   assign doWrite = rxByteValid && (cmdState == ST_WDATA);
   assign writeOk = doWrite && (wrAddr <= LAST_REG);

   // Interface timeout
   assign timerActive = (cmdState != ST_SYNC_WAIT) && (cmdState != ST_TX);
   assign idleLimit = turboMode ? TIMER_W'(TIMEOUT_TURBO_CYCLES) :
      TIMER_W'(TIMEOUT_NORMAL_CYCLES);
   assign timedOut = timerActive && (idleCnt >= idleLimit);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idleCnt <= '0;
      end else if (!timerActive || rxEdge || timedOut) begin
         idleCnt <= '0;
      end else begin
         idleCnt <= idleCnt + 1'b1;
      end
   end

   // Transaction sequencer; each command starts from a fresh sync byte
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmdState <= ST_SYNC_WAIT;
      end else if (timedOut) begin
         cmdState <= ST_SYNC_WAIT;
      end else begin
         unique case (cmdState)
            ST_SYNC_WAIT: begin
               if (rxFall) begin
                  cmdState <= ST_SYNC_MEAS;
               end
            end
            ST_SYNC_MEAS: begin
               if (rxFall && fallCnt == SYNC_LAST_FALL) begin
                  cmdState <= ST_SYNC_END;
               end
            end
            ST_SYNC_END: begin
               if (rxSync) begin
                  cmdState <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (doRdata || doRreg) begin
                  cmdState <= ST_TX;
               end else if (doWreg) begin
                  cmdState <= ST_WDATA;
               end else if (rxByteValid) begin
                  cmdState <= ST_SYNC_WAIT;
               end
            end
            ST_WDATA: begin
               if (rxByteValid) begin
                  cmdState <= ST_SYNC_WAIT;
               end
            end
            ST_TX: begin
               if (txLeft == 2'h0 && !txBusy) begin
                  cmdState <= ST_SYNC_WAIT;
               end
            end
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrAddr <= 3'h0;
         for (int i = 0; i < NUM_REGS; i++) begin
            cfgReg[i] <= REG_RESET;
         end
      end else if (doReset) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            cfgReg[i] <= REG_RESET;
         end
      end else begin
         if (doWreg) begin
            wrAddr <= rxByte[3:1];
         end
         if (writeOk) begin
            cfgReg[wrAddr] <= rxByte;
         end
      end
   end

   always_comb begin
      readVal = 8'h00;
      if (rxByte[3:1] <= LAST_REG) begin
         readVal = cfgReg[rxByte[3:1]];
         if (rxByte[3:1] == FIFTH_CONFIG_REG && !pinDir) begin
            readVal[PIN_DAT_BIT] = gpSync;
         end
      end
   end

   // Conversion and power control
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         asleep <= 1'b1;
         converting <= 1'b0;
         pendingSleep <= 1'b0;
         convStart <= 1'b0;
      end else begin
         convStart <= 1'b0;
         if (convDone && converting && (!convMode || pendingSleep)) begin
            converting <= 1'b0;
            if (pendingSleep) begin
               asleep <= 1'b1;
               pendingSleep <= 1'b0;
            end
         end
         if (doReset) begin
            asleep <= 1'b1;
            converting <= 1'b0;
            pendingSleep <= 1'b0;
         end else if (doStart) begin
            asleep <= 1'b0;
            pendingSleep <= 1'b0;
            converting <= 1'b1;
            convStart <= 1'b1;
         end else if (writeOk && converting) begin
            convStart <= 1'b1;
         end else if (doSleep) begin
            if (converting && !convDone) begin
               pendingSleep <= 1'b1;
            end else begin
               asleep <= 1'b1;
               converting <= 1'b0;
            end
         end
      end
   end

   assign convRun = converting;
   // Config is held while asleep, so waking returns every section as it was
   assign analogPowerOn = ~asleep;
   assign excitationCurrentSourceOn = ~asleep;

   // Result capture and ready flag
   assign newRes = convDone && converting;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         resultLatest <= '0;
         unread <= 1'b0;
         pulseCnt <= 4'h0;
      end else begin
         if (newRes) begin
            resultLatest <= clipRaw(convRaw);
         end
         if (doReset) begin
            unread <= 1'b0;
         end else if (newRes) begin
            unread <= 1'b1;
         end else if (doRdata) begin
            unread <= 1'b0;
         end
         if (newRes && unread && convMode) begin
            pulseCnt <= READY_PULSE_CYC;
         end else if (pulseCnt != 4'h0) begin
            pulseCnt <= pulseCnt - 1'b1;
         end
      end
   end

   assign conversionReadyN = ~unread | (pulseCnt != 4'h0);
   assign sharedGpPinOe = pinDir;
   assign sharedGpPinOut = (pinDir && pinSel) ? conversionReadyN :
      cfgReg[FIFTH_CONFIG_REG][PIN_DAT_BIT];

   // Answer buffer, least significant byte first
   assign txReq.valid = (cmdState == ST_TX) && (txLeft != 2'h0);
   assign txReq.data = txBuf[7:0];
   assign txAccept = txReq.valid && txReady;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txBuf <= '0;
         txLeft <= 2'h0;
      end else if (doRdata) begin
         txBuf <= resultLatest;
         txLeft <= 2'h3;
      end else if (doRreg) begin
         txBuf <= {16'h0000, readVal};
         txLeft <= 2'h1;
      end else if (txAccept) begin
         txBuf <= {8'h00, txBuf[RESULT_W-1:8]};
         txLeft <= txLeft - 1'b1;
      end
   end

   uacp_tx u_tx (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .bitPeriod(bitPeriod),
      .txReq(txReq),
      .txReady(txReady),
      .txLine(txPin),
      .txBusy(txBusy)
   );

   a_sleep_no_start: assert property (@(posedge core_clk) disable iff (sys_rst)
      asleep |-> !convStart)
      else $error("conversion started while asleep");

   a_wake_on_start: assert property (@(posedge core_clk) disable iff (sys_rst)
      doStart |=> (!asleep && convStart && converting))
      else $error("start command did not wake and start");

   a_half_duplex: assert property (@(posedge core_clk) disable iff (sys_rst)
      (cmdState == ST_TX) |-> (rxState == RX_IDLE && !rxByteValid))
      else $error("receiver active while transmitting");

   a_ready_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
      (newRes && unread && convMode && !doReset) |=>
         conversionReadyN ##5 (!conversionReadyN || !unread))
      else $error("unread result pulse has wrong width");

   a_ready_release: assert property (@(posedge core_clk) disable iff (sys_rst)
      (doRdata && !newRes && pulseCnt == 4'h0) |=> conversionReadyN)
      else $error("ready not released on result load");

   a_clip_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
      (newRes && convRaw > RAW_POS_LIMIT) |=> resultLatest == RESULT_MAX)
      else $error("positive overrange not clipped");

   a_bad_reg_read_cmd: assert property (@(posedge core_clk) disable iff (sys_rst)
      (doRreg && rxByte[3:1] > LAST_REG) |=> (txBuf == '0 && txLeft == 2'h1))
      else $error("missing register did not read zero");

   a_reg_write_cmd_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
      (writeOk && converting && !doReset) |=> convStart)
      else $error("accepted write did not restart conversion");

   a_timeout_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
      timedOut |=> (cmdState == ST_SYNC_WAIT && idleCnt == '0))
      else $error("timeout did not reset the interface");
endmodule
`default_nettype wire

// ### tb/uacp_host.sv
// Purpose: Host end of the serial link
// Assumes: Fixed bit period of BIT clocks, 8-N-1
// Notes: Line held high while idle
`timescale 1ns/10ps
`default_nettype none
module uacp_host #(
   parameter int BIT = 16
) (
   input wire logic core_clk,
   input wire logic devTx,
   output logic hostTx
);
   initial hostTx = 1'b1;
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         hostTx <= f[i];
         repeat (BIT) @(posedge core_clk);
      end
   endtask
   // Sync first, and only once the device line is seen high
   task automatic send_cmd(input logic [7:0] c, input logic [7:0] d, input bit two);
      wait (devTx === 1'b1);
      @(posedge core_clk);
      send_byte(8'h55);
      send_byte(c);
      if (two) send_byte(d);
   endtask
   task automatic recv_byte(output logic [7:0] b, output logic stp);
      @(negedge devTx);
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge core_clk);
         b[i] = devTx;
      end
      repeat (BIT) @(posedge core_clk);
      stp = devTx;
   endtask
endmodule
`default_nettype wire

// ### tb/uacp_core_bench.sv
// Purpose: Self-checking bench of the serial command port
// Assumes: Host bit period 16 clocks, short timeout limit
// Notes: Replies are checked against a queue of expected bytes
`timescale 1ns/10ps
`default_nettype none
module uacp_core_bench;
   import uacp_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, rxPin, txPin, gpOut, gpOe, rdyN;
   logic convStart, convRun, convDone = 1'b0, aOn, iOn, turbo, gpIn = 1'b0;
   logic signed [RAW_W-1:0] convRaw = '0;
   logic [7:0] exp[$];
   int badCount = 0, cmpCount = 0, starts = 0;
   uacp_host #(.BIT(16)) host (.core_clk(core_clk), .devTx(txPin), .hostTx(rxPin));
   uacp_core #(.TIMEOUT_NORMAL_CYCLES(200), .TIMEOUT_TURBO_CYCLES(200)) dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .rxPin(rxPin), .txPin(txPin),
      .sharedGpPinIn(gpIn), .sharedGpPinOut(gpOut), .sharedGpPinOe(gpOe),
      .conversionReadyN(rdyN), .convStart(convStart), .convRun(convRun),
      .convDone(convDone), .convRaw(convRaw), .analogPowerOn(aOn),
      .excitationCurrentSourceOn(iOn), .turboMode(turbo));
   initial forever #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (convStart === 1'b1) starts++;
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
      cmpCount++;
      if (seen !== want) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] d = 8'h00, input bit two = 0);
      host.send_cmd(c, d, two);
      for (int i = 0; i < 2000 && exp.size() != 0; i++) @(posedge core_clk);
      repeat (48) @(posedge core_clk);
      #1;
   endtask
   task automatic conv(input logic signed [RAW_W-1:0] r);
      @(posedge core_clk);
      convRaw <= r;
      convDone <= 1'b1;
      @(posedge core_clk);
      convDone <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   initial begin
      logic [7:0] b;
      logic s;
      forever begin
         host.recv_byte(b, s);
         check("tx stop", s, 1);
         if (exp.size() == 0) check("tx extra", 1, 0);
         else check("tx byte", b, exp.pop_front());
      end
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      badCount++;
      report_and_stop();
   end
   initial begin
      logic signed [RAW_W-1:0] r;
      logic [23:0] w;
      int s0;
      void'($urandom(32'h9418_0937));
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      gpIn <= 1'($urandom);
      repeat (4) @(posedge core_clk);
      #1;
      check("tx idle", txPin, 1);
      check("ready idle", rdyN, 1);
      cmd(8'h49, 8'h48, 1);
      check("pin oe", gpOe, 1);
      cmd(8'h44, 8'hA5, 1);
      cmd(8'h4B, 8'hFF, 1); // Missing address
      exp = '{8'h48, 8'hA5, 8'h00};
      cmd(8'h28);
      cmd(8'h25);
      cmd(8'h2B);
      $display("test registers done");
      for (int k = 0; k < 3; k++) begin
         s0 = starts;
         cmd(8'h09); // Lowest bit ignored
         check("start pulse", starts - s0, 1);
         check("running", convRun, 1);
         r = $signed(26'($urandom)) >>> (k * 2);
         w = (r > RAW_POS_LIMIT) ? RESULT_MAX : (r < RAW_NEG_LIMIT) ? RESULT_MIN : r[23:0];
         conv(r);
         check("ready low", rdyN, 0);
         check("pin ready", gpOut, 0);
         check("single ends", convRun, 0);
         exp = '{w[7:0], w[15:8], w[23:16]};
         cmd(8'h1F);
         check("ready high", rdyN, 1);
      end
      $display("test single done");
      cmd(8'h42, 8'h18, 1);
      check("turbo", turbo, 1);
      cmd(8'h08);
      conv(26'sd5);
      conv(26'sd6);
      check("ready pulse", rdyN, 1);
      repeat (4) @(posedge core_clk);
      #1;
      check("newer ready", rdyN, 0);
      s0 = starts;
      cmd(8'h08);
      check("restart", starts - s0, 1);
      s0 = starts;
      cmd(8'h44, 8'h5A, 1);
      check("write restart", starts - s0, 1);
      cmd(8'h03);
      check("finish first", aOn, 1);
      conv(26'sd7);
      check("asleep", {convRun, aOn, iOn}, 0);
      cmd(8'h08);
      check("awake", {convRun, aOn, iOn}, 3'b111);
      $display("test sleep done");
      cmd(8'h07);
      check("defaults", {convRun, rdyN, gpOe, turbo}, 4'b0100);
      repeat (1400) @(posedge core_clk);
      host.send_byte(8'h55);
      repeat (400) @(posedge core_clk);
      host.send_byte(8'h24); // Dropped after idle limit
      repeat (600) @(posedge core_clk);
      exp = '{8'h00};
      cmd(8'h24);
      exp = '{{5'h00, gpIn, 2'h0}};
      cmd(8'h28);
      $display("test timeout done");
      report_and_stop();
   end
endmodule
`default_nettype wire
